// ### src/stim3_params.svh
// constants for the stimulus-3 response configuration block
`ifndef STIM3_PARAMS_SVH
`define STIM3_PARAMS_SVH
`define S3_RESP_ADDR 8'h4a
`define S3_THR_ADDR 8'h4b
`define S3_RESET_VAL 8'h00
`define FIELD4_ZERO 4'h0
`define FIELD2_ZERO 2'h0
`define MV_ZERO 12'h000
`define MAG_HI 7
`define MAG_LO 4
`define SEL_HI 3
`define SEL_LO 0
`define PUPD_HI 5
`define PUPD_LO 4
`define TH_HI 3
`define TH_LO 0
`define SEL_REMOVE 4'h0
`define SEL_V_DP 4'h1
`define SEL_V_DM 4'h2
`define SEL_V_BOTH 4'h3
`define SEL_R_DP 4'h4
`define SEL_RSV_A 4'h5
`define SEL_DIV_DP 4'h6
`define SEL_R_DM 4'h7
`define SEL_RSV_B 4'h8
`define SEL_DIV_DM 4'h9
`define SEL_SHORT 4'ha
`define SEL_RSV_C 4'hb
`define SEL_DIV_BOTH 4'hc
`define SEL_R_BOTH 4'hd
`define SEL_PD_CTL 4'he
`define SEL_PD_CTL2 4'hf
`define CODE_RSV 4'hf
`define COND_VBUS_READY 3'h0
`define COND_VBUS_PRESENT 3'h7
`define UA_CODE0 8'h0a
`define UA_CODE1 8'h32
`define UA_CODE2 8'h64
`define UA_CODE3 8'h96
`endif

// ### src/stim3_pkg.sv
// types shared by the stimulus-3 response configuration block
package stim3_pkg;
   // kind of response held on one data line, one-hot
   typedef enum logic [4:0] {
      RESP_NONE = 5'h01,
      RESP_VOLT = 5'h02,
      RESP_RES = 5'h04,
      RESP_DIV = 5'h08,
      RESP_SHORT = 5'h10
   } resp_kind_t;
endpackage : stim3_pkg

// ### src/stim3_line_if.sv
// carrier between the register bank and one data-line response unit
`timescale 1ns/100ps
`default_nettype none
interface stim3_line_if;
   logic [3:0] sel;
   logic [3:0] mag;
   logic [2:0] cond3;
   logic [2:0] cond1;
   logic apply;
   logic emu_rst;
   stim3_pkg::resp_kind_t kind;
   logic pd_on;
   logic [3:0] mag_out;
   modport ctrl (output sel, mag, cond3, cond1, apply, emu_rst,
      input kind, pd_on, mag_out);
   modport line (input sel, mag, cond3, cond1, apply, emu_rst,
      output kind, pd_on, mag_out);
endinterface : stim3_line_if
`default_nettype wire

// ### src/stim3_level_lut.sv
// maps a 4-bit level code to millivolts
`timescale 1ns/100ps
`default_nettype none
module stim3_level_lut #(
   parameter bit LOW_300 = 1'b0
) (
   input wire logic [3:0] code, // level code
   output logic [11:0] mv // level in millivolts
);
   // table; the threshold variant drops code 3 to 300 mV
   always_comb begin
      case (code)
         4'h0: mv = LOW_300 ? 12'h190 : 12'h000;
         4'h1, 4'h2, 4'h4: mv = 12'h190;
         4'h3: mv = LOW_300 ? 12'h12c : 12'h190;
         4'h5: mv = 12'h1f4;
         4'h6: mv = 12'h258;
         4'h7: mv = 12'h2bc;
         4'h8: mv = 12'h320;
         4'h9: mv = 12'h384;
         4'ha: mv = 12'h578;
         4'hb: mv = 12'h640;
         4'hc: mv = 12'h708;
         4'hd: mv = 12'h7d0;
         4'he: mv = 12'h898;
         default: mv = 12'h000;
      endcase
   end
endmodule : stim3_level_lut
`default_nettype wire

// ### src/stim3_line_resp.sv
// response state of one data line (D+ or D-)
`include "stim3_params.svh"
`timescale 1ns/100ps
`default_nettype none
module stim3_line_resp #(
   parameter bit IS_DPLUS = 1'b1
) (
   input wire logic clk_sys, // system clock
   input wire logic rstn, // synchronous reset, active low
   stim3_line_if.line lif // controls in, line state out
);
   import stim3_pkg::*;
   resp_kind_t kind_q;
   logic pd_q;
   logic applied_q;
   logic [3:0] mag_q;
   logic v_hit, r_hit, d_hit, s_hit, pd_ctl, keep_pd;

   // which part of the select code concerns this line
   always_comb begin
      v_hit = lif.sel == `SEL_V_BOTH ||
         lif.sel == (IS_DPLUS ? `SEL_V_DP : `SEL_V_DM);
      r_hit = lif.sel == `SEL_R_BOTH ||
         lif.sel == (IS_DPLUS ? `SEL_R_DP : `SEL_R_DM);
      d_hit = lif.sel == `SEL_DIV_BOTH ||
         lif.sel == (IS_DPLUS ? `SEL_DIV_DP : `SEL_DIV_DM);
      s_hit = lif.sel == `SEL_SHORT;
      pd_ctl = lif.sel == `SEL_PD_CTL || lif.sel == `SEL_PD_CTL2;
      keep_pd = lif.cond1 == `COND_VBUS_READY && !applied_q;
   end

   // response kind and magnitude held on the line
   always_ff @(posedge clk_sys) begin
      if (!rstn || lif.emu_rst) begin
         kind_q <= RESP_NONE;
         mag_q <= `FIELD4_ZERO;
      end else if (lif.apply) begin
         if (v_hit) begin
            kind_q <= RESP_VOLT;
            mag_q <= lif.mag;
         end else if (r_hit) begin
            kind_q <= RESP_RES;
            mag_q <= lif.mag;
         end else if (d_hit) begin
            kind_q <= RESP_DIV;
            mag_q <= lif.mag;
         end else if (s_hit) begin
            kind_q <= RESP_SHORT;
         end else if (lif.sel == `SEL_REMOVE) begin
            kind_q <= RESP_NONE;
         end
      end
   end

   // emulation-reset pull-down and applied history
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         pd_q <= 1'b0;
         applied_q <= 1'b0;
      end else if (lif.emu_rst) begin
         pd_q <= 1'b1;
         applied_q <= 1'b0;
      end else if (lif.apply) begin
         if (v_hit || r_hit || d_hit || s_hit) begin
            pd_q <= 1'b0;
            applied_q <= 1'b1;
         // pull-down keep or drop, both codes
         end else if (pd_ctl) begin
            if (lif.cond3 == `COND_VBUS_PRESENT) begin
               pd_q <= 1'b0;
            end
         end else if (!keep_pd && !applied_q) begin
            pd_q <= 1'b0;
         end
      end
   end

   assign lif.kind = kind_q;
   assign lif.pd_on = pd_q;
   assign lif.mag_out = mag_q;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   volt_apply_a: assert property (
      lif.apply && !lif.emu_rst && v_hit |=> kind_q == RESP_VOLT &&
         mag_q == $past(lif.mag))
      else $error("voltage response not taken");
   pd_drop_a: assert property (
      lif.apply && !lif.emu_rst && pd_ctl &&
         lif.cond3 == `COND_VBUS_PRESENT |=> !pd_q)
      else $error("pull-down kept on condition 111");
   pd_keep_a: assert property (
      lif.apply && !lif.emu_rst && lif.sel == `SEL_REMOVE && keep_pd &&
         pd_q |=> pd_q && kind_q == RESP_NONE)
      else $error("reset pull-down lost");
   divider_hit_a: assert property (
      lif.apply && !lif.emu_rst && d_hit |=> kind_q == RESP_DIV)
      else $error("divider response not taken");
endmodule : stim3_line_resp
`default_nettype wire

// ### src/stim3_resp_config.sv
// stimulus-3 response configuration registers and their application
// Behaviour
// - writes of reserved codes are dropped; the field keeps its old value
// - select 0000 removes responses; 0001-0011 apply voltage on D+, D-, both
// - select 0100, 0111, 1101 connect resistors to ground on D+, D-, both
// - select 0110, 1001, 1100 connect a vbus divider to D+, D-, both
// - select 1110: condition 000 keeps, 111 drops reset pull-downs
// - select 1111 behaves exactly like select 1110
// - voltage magnitude: 0000 pull-down, then 400 mV up to 2200 mV
// - resistor magnitude 1.8k to 150k; code 1111 reserved
// - divider magnitude 93k to 200k, repeating; code 1111 reserved
// - untouched line keeps reset pull-down when stimulus-1 condition is 000
// - pull-down current 10, 50, 100, 150 uA for codes 00 to 11
// - threshold 400 mV, 300 mV at 0011, up to 2200 mV; 1111 reserved
// - threshold and current are frozen while a legacy profile runs
// - conditions 000 and 111 do not wait for removal; threshold unused
`include "stim3_params.svh"
`timescale 1ns/100ps
`default_nettype none
module stim3_resp_config (
   input wire logic clk_sys, // system clock, 50 MHz
   input wire logic rstn, // synchronous reset, active low
   input wire logic reg_wr_en, // register write strobe
   input wire logic [7:0] reg_addr, // register address
   input wire logic [7:0] reg_wdata, // register write data
   output logic [7:0] reg_rdata_q, // read data, one cycle late
   input wire logic [2:0] stim3_condition_select, // stimulus-3 condition
   input wire logic [2:0] condition_select_a, // stimulus-1 condition
   input wire logic legacy_active, // legacy profile in progress
   input wire logic stim3_apply, // stimulus 3 detected, apply pulse
   input wire logic emu_reset, // emulation reset pulse
   output stim3_pkg::resp_kind_t dplus_kind_q, // D+ response kind
   output logic dplus_pd_q, // D+ reset pull-down on
   output logic [3:0] dplus_mag_q, // D+ magnitude code
   output stim3_pkg::resp_kind_t dminus_kind_q, // D- response kind
   output logic dminus_pd_q, // D- reset pull-down on
   output logic [3:0] dminus_mag_q, // D- magnitude code
   output logic [11:0] response_mv_q, // applied response voltage
   output logic [11:0] threshold_mv_q, // applied threshold voltage
   output logic [7:0] pulldown_ua_q, // applied pull-down current
   output logic stim3_no_wait_q // next stimulus does not wait
);
   import stim3_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // register state
   logic [3:0] stim3_response_select_q;
   logic [3:0] stim3_response_magnitude_q;
   logic [1:0] stim3_pulldown_current_q;
   logic [3:0] stim3_threshold_q;
   logic [3:0] sel_wr, sel_d, mag_wr, mag_d, th_wr, th_d;
   logic sel_ok, mag_ok, th_ok, uses_mag;
   logic wr_resp, wr_thr;
   logic [11:0] resp_lut_mv, thr_lut_mv;
   logic [7:0] ua_d;
   logic is_volt;

   stim3_line_if dp_if ();
   stim3_line_if dm_if ();

   ////////////////////////////////////////////////////////////////////////
   // write decode
   always_comb begin
      wr_resp = 1'b0;
      wr_thr = 1'b0;
      if (reg_wr_en && reg_addr == `S3_RESP_ADDR) begin
         wr_resp = 1'b1;
      end else if (reg_wr_en && reg_addr == `S3_THR_ADDR) begin
         wr_thr = 1'b1;
      end
   end

   // reserved-code screening of written fields
   always_comb begin
      sel_wr = reg_wdata[`SEL_HI:`SEL_LO];
      mag_wr = reg_wdata[`MAG_HI:`MAG_LO];
      th_wr = reg_wdata[`TH_HI:`TH_LO];
      sel_ok = !(sel_wr == `SEL_RSV_A || sel_wr == `SEL_RSV_B ||
         sel_wr == `SEL_RSV_C);
      sel_d = sel_ok ? sel_wr : stim3_response_select_q;
      // magnitude 1111 is reserved where magnitude applies
      uses_mag = sel_d != `SEL_SHORT;
      mag_ok = !(mag_wr == `CODE_RSV && uses_mag);
      mag_d = mag_ok ? mag_wr : stim3_response_magnitude_q;
      th_ok = th_wr != `CODE_RSV;
      th_d = th_ok ? th_wr : stim3_threshold_q;
   end

   // response register
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         stim3_response_select_q <= `FIELD4_ZERO;
         stim3_response_magnitude_q <= `FIELD4_ZERO;
      end else if (wr_resp) begin
         stim3_response_select_q <= sel_d;
         stim3_response_magnitude_q <= mag_d;
      end
   end

   // threshold register; bits 7-6 are not stored
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         stim3_pulldown_current_q <= `FIELD2_ZERO;
         stim3_threshold_q <= `FIELD4_ZERO;
      end else if (wr_thr) begin
         stim3_pulldown_current_q <= reg_wdata[`PUPD_HI:`PUPD_LO];
         stim3_threshold_q <= th_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read path, registered
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         reg_rdata_q <= `S3_RESET_VAL;
      end else if (reg_addr == `S3_RESP_ADDR) begin
         reg_rdata_q <= {stim3_response_magnitude_q,
            stim3_response_select_q};
      end else if (reg_addr == `S3_THR_ADDR) begin
         reg_rdata_q <= {2'b00, stim3_pulldown_current_q,
            stim3_threshold_q};
      end else begin
         reg_rdata_q <= `S3_RESET_VAL;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // level tables
   stim3_level_lut #(.LOW_300(1'b0)) resp_lut (
      .code(stim3_response_magnitude_q),
      .mv(resp_lut_mv)
   );

   stim3_level_lut #(.LOW_300(1'b1)) thr_lut (
      .code(stim3_threshold_q),
      .mv(thr_lut_mv)
   );

   always_comb begin
      case (stim3_pulldown_current_q)
         2'h0: ua_d = `UA_CODE0;
         2'h1: ua_d = `UA_CODE1;
         2'h2: ua_d = `UA_CODE2;
         default: ua_d = `UA_CODE3;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // applied threshold and current
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         threshold_mv_q <= `MV_ZERO;
         pulldown_ua_q <= `S3_RESET_VAL;
      end else if (!legacy_active) begin
         threshold_mv_q <= thr_lut_mv;
         pulldown_ua_q <= ua_d;
      end
   end

   // level of the magnitude code at the last apply with select 0000 to 0011
   always_comb begin
      is_volt = stim3_response_select_q <= `SEL_V_BOTH;
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn || emu_reset) begin
         response_mv_q <= 12'h000;
      end else if (stim3_apply && is_volt) begin
         response_mv_q <= resp_lut_mv;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         stim3_no_wait_q <= 1'b1;
      end else begin
         stim3_no_wait_q <=
            stim3_condition_select == `COND_VBUS_READY ||
            stim3_condition_select == `COND_VBUS_PRESENT;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // per-line response units
   always_comb begin
      dp_if.sel = stim3_response_select_q;
      dp_if.mag = stim3_response_magnitude_q;
      dp_if.cond3 = stim3_condition_select;
      dp_if.cond1 = condition_select_a;
      dp_if.apply = stim3_apply;
      dp_if.emu_rst = emu_reset;
      dm_if.sel = stim3_response_select_q;
      dm_if.mag = stim3_response_magnitude_q;
      dm_if.cond3 = stim3_condition_select;
      dm_if.cond1 = condition_select_a;
      dm_if.apply = stim3_apply;
      dm_if.emu_rst = emu_reset;
   end

   stim3_line_resp #(.IS_DPLUS(1'b1)) dplus_unit (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .lif(dp_if.line)
   );

   stim3_line_resp #(.IS_DPLUS(1'b0)) dminus_unit (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .lif(dm_if.line)
   );

   // line state straight from the unit flip-flops
   assign dplus_kind_q = dp_if.kind;
   assign dplus_pd_q = dp_if.pd_on;
   assign dplus_mag_q = dp_if.mag_out;
   assign dminus_kind_q = dm_if.kind;
   assign dminus_pd_q = dm_if.pd_on;
   assign dminus_mag_q = dm_if.mag_out;

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   sel_reject_a: assert property (
      wr_resp && !sel_ok |=>
         stim3_response_select_q == $past(stim3_response_select_q))
      else $error("reserved select accepted");
   mag_reject_a: assert property (
      wr_resp && mag_wr == `CODE_RSV && uses_mag |=>
         stim3_response_magnitude_q == $past(stim3_response_magnitude_q))
      else $error("reserved magnitude accepted");
   thr_reject_a: assert property (
      wr_thr && th_wr == `CODE_RSV |=>
         stim3_threshold_q == $past(stim3_threshold_q))
      else $error("reserved threshold accepted");
   thr_freeze_a: assert property (
      legacy_active |=> $stable(threshold_mv_q) && $stable(pulldown_ua_q))
      else $error("threshold moved under legacy profile");
   ua_decode_a: assert property (
      !legacy_active && stim3_pulldown_current_q == 2'h3 ##1
         $stable(stim3_pulldown_current_q) |-> pulldown_ua_q == `UA_CODE3)
      else $error("pull-down current wrong");
   both_resist_a: assert property (
      stim3_apply && !emu_reset &&
         stim3_response_select_q == `SEL_R_BOTH |=>
         dplus_kind_q == RESP_RES && dminus_kind_q == RESP_RES)
      else $error("resistor not on both lines");
   pd_same_a: assert property (
      stim3_apply && !emu_reset &&
         stim3_response_select_q == `SEL_PD_CTL2 &&
         stim3_condition_select == `COND_VBUS_PRESENT |=>
         !dplus_pd_q && !dminus_pd_q)
      else $error("select 1111 differs from 1110");
   nowait_cond_a: assert property (
      stim3_condition_select == `COND_VBUS_PRESENT |=> stim3_no_wait_q)
      else $error("no-wait flag missing");
   read_zero_a: assert property (
      reg_addr == `S3_THR_ADDR |=> reg_rdata_q[7:6] == 2'b00)
      else $error("unimplemented bits read set");
   volt_level_a: assert property (
      stim3_apply && !emu_reset && stim3_response_select_q == `SEL_V_DP &&
         stim3_response_magnitude_q == 4'h1 |=>
         response_mv_q == 12'h190)
      else $error("voltage level wrong");
   remove_both_a: assert property (
      stim3_apply && !emu_reset && stim3_response_select_q == `SEL_REMOVE |=>
         dplus_kind_q == RESP_NONE && dminus_kind_q == RESP_NONE)
      else $error("removal left a response");
   res_mag_a: assert property (
      stim3_apply && !emu_reset && stim3_response_select_q == `SEL_R_DP |=>
         dplus_kind_q == RESP_RES &&
         dplus_mag_q == $past(stim3_response_magnitude_q))
      else $error("resistor value not taken");
   div_mag_a: assert property (
      stim3_apply && !emu_reset &&
         stim3_response_select_q == `SEL_DIV_BOTH |=>
         dplus_mag_q == $past(stim3_response_magnitude_q) &&
         dminus_mag_q == $past(stim3_response_magnitude_q))
      else $error("divider value not taken");
   thr_level_a: assert property (
      !legacy_active && stim3_threshold_q == 4'h3 |=>
         threshold_mv_q == 12'h12c)
      else $error("threshold 0011 not 300 mV");

   cover_volt_c: cover property (
      stim3_apply && stim3_response_select_q == `SEL_V_BOTH);
   cover_div_c: cover property (
      stim3_apply && stim3_response_select_q == `SEL_DIV_BOTH);
   cover_reject_c: cover property (wr_resp && !sel_ok);
   cover_legacy_c: cover property (legacy_active && wr_thr);
   cover_short_c: cover property (stim3_apply && stim3_response_select_q == `SEL_SHORT);
endmodule : stim3_resp_config
`default_nettype wire

// ### testbench/usb_portable_model.sv
// behavioural portable device that raises the stimulus detect pulse
`timescale 1ns/100ps
`default_nettype none
module usb_portable_model (
   input wire logic clk_sys, // system clock
   input wire logic go, // request one stimulus
   input wire logic [3:0] delay, // cycles to wait before the pulse
   output logic apply, // one-cycle stimulus detect pulse
   output logic busy // request pending
);
   logic g;
   logic [3:0] cnt;
   // sample the request at the edge, act just after it, pulse one cycle
   initial begin
      apply = 1'b0;
      busy = 1'b0;
      cnt = 4'h0;
      forever begin
         @(posedge clk_sys);
         g = go;
         #1;
         apply = 1'b0;
         if (busy && cnt == 4'h0) begin
            apply = 1'b1;
            busy = 1'b0;
         end else if (busy) begin
            cnt = cnt - 4'h1;
         end else if (g) begin
            busy = 1'b1;
            cnt = delay;
         end
      end
   end
endmodule : usb_portable_model
`default_nettype wire

// ### testbench/emulation_stim3_response_config_tb_top.sv
// self-checking bench for the stimulus-3 response registers
`timescale 1ns/100ps
`default_nettype none
module emulation_stim3_response_config_tb_top;
   import stim3_pkg::*;
   logic clk_sys, rstn, reg_wr_en, legacy_active, emu_reset, go, apply, busy;
   logic [7:0] reg_addr, reg_wdata, reg_rdata_q, pulldown_ua_q, r_resp, r_thr;
   logic [2:0] cond3, cond1;
   logic [3:0] dly, dp_mag, dm_mag, m;
   logic dp_pd, dm_pd, no_wait, pe;
   resp_kind_t dp_kind, dm_kind, k;
   logic [11:0] resp_mv, thr_mv;
   int miscompares, tests_run;

   stim3_resp_config dut (.clk_sys(clk_sys), .rstn(rstn),
      .reg_wr_en(reg_wr_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata_q(reg_rdata_q), .stim3_condition_select(cond3),
      .condition_select_a(cond1), .legacy_active(legacy_active),
      .stim3_apply(apply), .emu_reset(emu_reset), .dplus_kind_q(dp_kind),
      .dplus_pd_q(dp_pd), .dplus_mag_q(dp_mag), .dminus_kind_q(dm_kind),
      .dminus_pd_q(dm_pd), .dminus_mag_q(dm_mag), .response_mv_q(resp_mv),
      .threshold_mv_q(thr_mv), .pulldown_ua_q(pulldown_ua_q),
      .stim3_no_wait_q(no_wait));
   usb_portable_model peer (.clk_sys(clk_sys), .go(go), .delay(dly),
      .apply(apply), .busy(busy));

   ////////////////////////////////////////////////////////////////////////
   // expectation functions
   function automatic logic [11:0] lvl_mv(input logic [3:0] c, input bit th);
      case (c)
         4'h0: lvl_mv = th ? 12'h190 : 12'h000;
         4'h1, 4'h2, 4'h4: lvl_mv = 12'h190;
         4'h3: lvl_mv = th ? 12'h12c : 12'h190;
         4'ha: lvl_mv = 12'h578;
         4'hb: lvl_mv = 12'h640;
         4'hc: lvl_mv = 12'h708;
         4'hd: lvl_mv = 12'h7d0;
         4'he: lvl_mv = 12'h898;
         default: lvl_mv = 12'(c) * 12'h064;
      endcase
   endfunction : lvl_mv
   function automatic logic [7:0] ua_of(input logic [1:0] c);
      ua_of = (c == 2'h0) ? 8'h0a : (c == 2'h1) ? 8'h32 :
         (c == 2'h2) ? 8'h64 : 8'h96;
   endfunction : ua_of
   // reserved select and magnitude codes leave the old field in place
   function automatic logic [7:0] exp_resp(input logic [7:0] o, w);
      logic [3:0] s;
      s = (w[3:0] inside {4'h5, 4'h8, 4'hb}) ? o[3:0] : w[3:0];
      exp_resp = {(w[7:4] == 4'hf && s != 4'ha) ?
         o[7:4] : w[7:4], s};
   endfunction : exp_resp
   function automatic logic [7:0] exp_thr(input logic [7:0] o, w);
      exp_thr = {2'h0, w[5:4], (w[3:0] == 4'hf) ? o[3:0] : w[3:0]};
   endfunction : exp_thr
   // kind of one line after an apply that follows an emulation reset
   function automatic resp_kind_t exp_kind(input logic [3:0] s, input bit p);
      case (s)
         4'h1: exp_kind = p ? RESP_VOLT : RESP_NONE;
         4'h2: exp_kind = p ? RESP_NONE : RESP_VOLT;
         4'h3: exp_kind = RESP_VOLT;
         4'h4: exp_kind = p ? RESP_RES : RESP_NONE;
         4'h7: exp_kind = p ? RESP_NONE : RESP_RES;
         4'hd: exp_kind = RESP_RES;
         4'h6: exp_kind = p ? RESP_DIV : RESP_NONE;
         4'h9: exp_kind = p ? RESP_NONE : RESP_DIV;
         4'hc: exp_kind = RESP_DIV;
         4'ha: exp_kind = RESP_SHORT;
         default: exp_kind = RESP_NONE;
      endcase
   endfunction : exp_kind

   ////////////////////////////////////////////////////////////////////////
   // compare, drive and report tasks
   task automatic chk(input string n, input logic [11:0] e, g);
      tests_run++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic chk_kind(input string n, input resp_kind_t e, g);
      tests_run++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk_kind
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : conclude
   task automatic step();
      @(posedge clk_sys);
      #1;
   endtask : step
   task automatic wr(input logic [7:0] a, d);
      reg_wr_en = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      step();
      reg_wr_en = 1'b0;
      if (a == 8'h4a) r_resp = exp_resp(r_resp, d);
      if (a == 8'h4b) r_thr = exp_thr(r_thr, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, e);
      reg_addr = a;
      step();
      chk("reg_rdata_q", 12'(e), 12'(reg_rdata_q));
   endtask : rd
   // emulation reset, then the peer fires a stimulus after a random delay
   task automatic emu_fire();
      int n;
      emu_reset = 1'b1;
      step();
      emu_reset = 1'b0;
      dly = 4'($urandom_range(0, 15));
      go = 1'b1;
      step();
      go = 1'b0;
      for (n = 0; n < 40; n++) begin
         @(posedge clk_sys);
         if (apply === 1'b1) break;
      end
      #1;
      if (n == 40 || busy !== 1'b0) begin
         miscompares++;
         conclude();
      end
   endtask : emu_fire

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   initial begin
      void'($urandom(31666));
      {rstn, reg_wr_en, legacy_active, emu_reset, go} = 5'h00;
      {reg_addr, reg_wdata, r_resp, r_thr} = 32'h0;
      {cond3, cond1, dly} = 10'h000;
      miscompares = 0;
      tests_run = 0;
      repeat (2) @(posedge clk_sys);
      #1 rstn = 1'b1;
      // reset values and the unmapped neighbour
      rd(8'h4a, 8'h00);
      rd(8'h4b, 8'h00);
      chk("threshold_mv_q", 12'h190, thr_mv);
      rd(8'h4c, 8'h00);
      // random writes with reserved codes, read back both registers
      wr(8'h4a, 8'hf1);
      rd(8'h4a, r_resp);
      wr(8'h4b, 8'h2f);
      rd(8'h4b, r_thr);
      wr(8'h4a, 8'hfe);
      rd(8'h4a, r_resp);
      wr(8'h4a, 8'h38);
      rd(8'h4a, r_resp);
      repeat (40) begin
         wr(8'h4a + 8'($urandom_range(0, 2)), 8'($urandom));
         rd(8'h4a, r_resp);
         rd(8'h4b, r_thr);
      end
      // every non-reserved select code applied after an emulation reset
      for (int s = 0; s < 16; s++) begin
         m = (s == 1) ? 4'h1 : 4'($urandom_range(0, 14));
         cond3 = (s != 14) ? 3'(s == 15 ? 7 : 0) :
            3'($urandom_range(0, 6));
         wr(8'h4a, {m, 4'(s)});
         rd(8'h4a, r_resp);
         if (r_resp[3:0] == 4'(s)) begin
            emu_fire();
            k = exp_kind(4'(s), 1'b1);
            pe = s != 15 && k == RESP_NONE;
            chk_kind("dplus_kind", k, dp_kind);
            chk("dplus_pd", 12'(pe), 12'(dp_pd));
            if (k != RESP_NONE && s != 10) begin
               chk("dplus_mag", 12'(m), 12'(dp_mag));
            end
            k = exp_kind(4'(s), 1'b0);
            pe = s != 15 && k == RESP_NONE;
            chk_kind("dminus_kind", k, dm_kind);
            chk("dminus_pd", 12'(pe), 12'(dm_pd));
            if (k != RESP_NONE && s != 10) begin
               chk("dminus_mag", 12'(m), 12'(dm_mag));
            end
            if (s < 4) chk("response_mv", lvl_mv(m, 1'b0), resp_mv);
         end
      end
      // stimulus-1 condition not 000 drops the untouched line's pull-down
      cond1 = 3'h3;
      wr(8'h4a, 8'h51);
      emu_fire();
      chk("dminus_pd", 12'h000, 12'(dm_pd));
      cond1 = 3'h0;
      // every threshold code but reserved 1111, and every current code
      for (int c = 0; c < 15; c++) begin
         wr(8'h4b, {2'h3, 2'(c), 4'(c)});
         step();
         chk("threshold_mv_q", lvl_mv(4'(c), 1'b1), thr_mv);
         chk("pulldown_ua_q", 12'(ua_of(2'(c))), 12'(pulldown_ua_q));
         rd(8'h4b, r_thr);
      end
      // outputs hold while a legacy profile runs, then follow again
      legacy_active = 1'b1;
      wr(8'h4b, 8'h35);
      step();
      chk("threshold_mv_q", 12'h898, thr_mv);
      chk("pulldown_ua_q", 12'h064, 12'(pulldown_ua_q));
      legacy_active = 1'b0;
      step();
      chk("threshold_mv_q", 12'h1f4, thr_mv);
      chk("pulldown_ua_q", 12'h096, 12'(pulldown_ua_q));
      // no-wait flag for every stimulus-3 condition
      for (int c = 0; c < 8; c++) begin
         cond3 = 3'(c);
         step();
         chk("stim3_no_wait", 12'(c == 0 || c == 7), 12'(no_wait));
      end
      conclude();
   end
endmodule : emulation_stim3_response_config_tb_top
`default_nettype wire
